// [bench/rtc_host_model.sv]
// Host serial master for the clock's link pins
module rtc_host_model (
	// Link pins
	output logic		o_sclk,
	output logic		o_cs_n,
	output logic		o_ce,
	output logic		o_din,
	output logic		o_line,
	// Device side
	input wire logic	i_three_wire,
	input wire logic	i_dout,
	input wire logic	i_sdio,
	input wire logic	i_sdio_oe_n
);
	timeunit 1ns;
	timeprecision 100ps;
	logic	host_oe = 1'b1;
	logic	hbit = 1'b0;
	// Released line shows the inverse so stale data never reads as valid
	assign o_line = !i_sdio_oe_n ? i_sdio : (host_oe ? hbit : ~hbit);
	initial begin
		o_sclk = 1'b0;
		o_cs_n = 1'b1;
		o_ce = 1'b0;
		o_din = 1'b0;
	end

	task automatic xfer(input logic [7:0] hdr, input logic [15:0] wr, input int nb, output logic [15:0] rd);
		logic [23:0] sh;
		sh = {hdr, wr};
		rd = 16'h0;
		host_oe = 1'b1;
		if (i_three_wire)
			o_ce = 1'b1;
		else
			o_cs_n = 1'b0;
		#20;
		for (int i = 0; i < 8 * (nb + 1); i++) begin
			o_din = sh[23];
			hbit = sh[23];
			if (i == 8 && !hdr[7])
				host_oe = 1'b0;
			#16 o_sclk = 1'b1;
			rd = {rd[14:0], i_three_wire ? o_line : i_dout};
			sh = {sh[22:0], 1'b0};
			#16 o_sclk = 1'b0;
		end
		#20 o_cs_n = 1'b1;
		o_ce = 1'b0;
		o_din = ~o_din;
		host_oe = 1'b1;
		#20;
	endtask : xfer
endmodule : rtc_host_model

// [bench/rtc_pins_checker.sv]
// Concurrent checks on the real-time clock pin logic
module rtc_pins_checker #(
	parameter int unsigned HOLD_CYCLES      = 20,
	parameter int unsigned OSC_START_CYCLES = 30
) (
	// Inputs
	input wire logic	i_core_clk,
	input wire logic	i_rst,
	input wire logic	i_three_wire,
	input wire logic	i_cs_n,
	input wire logic	i_ce,
	input wire logic	i_powerfail_threshold_ok,
	input wire logic	i_osc_disable,
	input wire logic	i_irq_enable,
	input wire logic	i_wave_output_enable,
	input wire logic	i_alarm_flag,
	// Outputs
	input wire logic	o_dout_oe_n,
	input wire logic	o_sdio_oe_n,
	input wire logic	o_wr_valid,
	input wire logic	o_rst_pin_oe_n,
	input wire logic	o_wave_or_irq_out_oe_n,
	input wire logic	o_irq_out_oe_n,
	input wire logic	o_square_wave_out_oe_n
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	// Cycles of good supply; saturates so long runs never wrap
	logic [31:0]	ok_run_r;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst)
			ok_run_r <= 32'h0;
		else if (!i_powerfail_threshold_ok)
			ok_run_r <= 32'h0;
		else if (ok_run_r != 32'hFFFFFFFF)
			ok_run_r <= ok_run_r + 32'h1;
	end

	a_fault_pull: assert property (!i_powerfail_threshold_ok [*4] |-> !o_rst_pin_oe_n)
		else $error("reset pin released during supply fault");
	a_hold_time: assert property ($rose(o_rst_pin_oe_n) |->
		ok_run_r >= HOLD_CYCLES + (i_osc_disable ? OSC_START_CYCLES : 0))
		else $error("reset pin released before hold delay");
	a_wr_blocked: assert property (o_wr_valid |-> o_rst_pin_oe_n)
		else $error("write accepted while access blocked");
	a_rd_blocked: assert property (!o_dout_oe_n || !o_sdio_oe_n |-> o_rst_pin_oe_n)
		else $error("read data driven while access blocked");
	a_wr_single: assert property (o_wr_valid |=> !o_wr_valid)
		else $error("write strobe longer than one cycle");
	a_dout_select: assert property (!o_dout_oe_n |-> !i_cs_n && !i_three_wire)
		else $error("data out driven while not selected");
	a_sdio_select: assert property (!o_sdio_oe_n |-> i_ce && i_three_wire && o_dout_oe_n)
		else $error("data line driven while not selected");
	a_irq_gate: assert property (!$past(i_rst) |->
		o_irq_out_oe_n == !$past(i_alarm_flag && i_irq_enable))
		else $error("interrupt pin does not follow its enable");
	a_combo_irq: assert property (!$past(i_rst) && !$past(i_wave_output_enable) |->
		o_wave_or_irq_out_oe_n == !$past(i_alarm_flag && i_irq_enable))
		else $error("combined pin wrong in interrupt mode");
	a_square_off: assert property (!$past(i_rst) && !$past(i_wave_output_enable) |-> o_square_wave_out_oe_n)
		else $error("square pin active while disabled");
	a_combo_wave: assert property (!$past(i_rst) && $past(i_wave_output_enable) |->
		o_wave_or_irq_out_oe_n == o_square_wave_out_oe_n)
		else $error("combined pin differs from square wave");

	c_write: cover property (o_wr_valid);
	c_release: cover property ($rose(o_rst_pin_oe_n));
	c_line_read: cover property (!o_sdio_oe_n);
	c_dout_read: cover property (!o_dout_oe_n);
endmodule : rtc_pins_checker

bind rtc_pins rtc_pins_checker #(.HOLD_CYCLES(HOLD_CYCLES), .OSC_START_CYCLES(OSC_START_CYCLES)) rtc_pins_checker_i (.*);

// [bench/tb_top.sv]
// Self-checking bench for the real-time clock pin logic
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic		i_core_clk = 1'b0, i_rst = 1'b1, i_osc_clk = 1'b0, button = 1'b0;
	logic		i_sclk, i_cs_n, i_ce, i_din, i_sdio, i_rst_pin, i_three_wire = 1'b0;
	logic		i_powerfail_threshold_ok = 1'b0, i_osc_disable = 1'b0;
	logic		i_irq_enable = 1'b0, i_wave_output_enable = 1'b0, i_alarm_flag = 1'b0;
	logic [1:0]	i_rate_sel = 2'h0;
	logic [63:0]	i_time = 64'h8877665544332211;
	logic		o_dout, o_dout_oe_n, o_sdio, o_sdio_oe_n, o_wr_valid, o_rst_pin, o_rst_pin_oe_n;
	logic		o_wave_or_irq_out, o_wave_or_irq_out_oe_n, o_irq_out, o_irq_out_oe_n;
	logic		o_square_wave_out, o_square_wave_out_oe_n;
	logic [3:0]	o_wr_addr;
	logic [7:0]	o_wr_data;
	logic [15:0]	rd;
	int		errors = 0, n_compared = 0, wr_cnt = 0, cycles = 0;

	always #2 i_core_clk = ~i_core_clk;
	// Oscillator sped up so debounce and all wave taps but 1 Hz fit a short run
	always #20 i_osc_clk = ~i_osc_clk;
	// Pin has a pull-up; device or pushbutton pulls it low
	assign i_rst_pin = o_rst_pin_oe_n & ~button;

	rtc_pins #(.HOLD_CYCLES(20), .OSC_START_CYCLES(30)) rtc_pins_i (.*);
	rtc_host_model rtc_host_model_i (.o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_ce(i_ce), .o_din(i_din),
		.o_line(i_sdio), .i_three_wire(i_three_wire), .i_dout(o_dout), .i_sdio(o_sdio),
		.i_sdio_oe_n(o_sdio_oe_n));

	task automatic summarize;
		$display("errors=%0d compared=%0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : summarize

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic step(input int n);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask : step

	task automatic wave(input logic [1:0] rate, input logic exp);
		logic first;
		logic first_sq;
		logic moved;
		logic moved_sq;
		i_rate_sel = rate;
		step(4);
		first = o_wave_or_irq_out_oe_n;
		first_sq = o_square_wave_out_oe_n;
		moved = 1'b0;
		moved_sq = 1'b0;
		repeat (200) begin
			step(1);
			moved = moved | (o_wave_or_irq_out_oe_n !== first);
			moved_sq = moved_sq | (o_square_wave_out_oe_n !== first_sq);
		end
		check(moved, exp);
		check(moved_sq, exp);
	endtask : wave

	task automatic press(input int n, input logic exp);
		logic low;
		low = 1'b0;
		button = 1'b1;
		repeat (n) begin
			step(1);
			low = low | !o_rst_pin_oe_n;
		end
		button = 1'b0;
		step(60);
		check({low, o_rst_pin_oe_n}, {exp, 1'b1});
	endtask : press

	always @(posedge i_core_clk) begin
		cycles <= cycles + 1;
		if (o_wr_valid === 1'b1)
			wr_cnt <= wr_cnt + 1;
		if (cycles == 20000) begin
			errors++;
			summarize();
		end
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		step(8);
		i_rst = 1'b0;
		step(4);
		check(o_rst_pin_oe_n, 1'b0);
		rtc_host_model_i.xfer(8'h81, 16'h5A00, 1, rd);
		step(6);
		check(wr_cnt[15:0], 16'h0);
		rtc_host_model_i.xfer(8'h00, 16'h0000, 1, rd);
		check(rd, 16'h0000);
		i_alarm_flag = 1'b1;
		step(2);
		check({o_irq_out_oe_n, o_wave_or_irq_out_oe_n}, 2'h3);
		i_irq_enable = 1'b1;
		step(2);
		check({o_irq_out_oe_n, o_wave_or_irq_out_oe_n, o_square_wave_out_oe_n}, 3'h1);
		i_wave_output_enable = 1'b1;
		for (int r = 0; r < 4; r++)
			wave(r[1:0], r != 0);
		check(o_irq_out_oe_n, 1'b0);
		check({o_rst_pin, o_wave_or_irq_out, o_irq_out, o_square_wave_out}, 4'h0);
		i_wave_output_enable = 1'b0;
		i_alarm_flag = 1'b0;
		i_powerfail_threshold_ok = 1'b1;
		step(15);
		check(o_rst_pin_oe_n, 1'b0);
		step(15);
		check(o_rst_pin_oe_n, 1'b1);
		rtc_host_model_i.xfer(8'h81, 16'h5A00, 1, rd);
		step(6);
		check({wr_cnt[3:0], o_wr_addr, o_wr_data}, 16'h115A);
		i_time = 64'h8877665544332299;
		// Time moves mid-frame; the read must still return the copy
		fork
			rtc_host_model_i.xfer(8'h0F, 16'h0000, 2, rd);
			begin
				step(20);
				i_time = 64'h0;
				step(60);
				check(o_dout_oe_n, 1'b0);
			end
		join
		check(rd, 16'h0099);
		check(o_dout_oe_n, 1'b1);
		i_time = 64'h8877665544332211;
		i_three_wire = 1'b1;
		step(2);
		rtc_host_model_i.xfer(8'h02, 16'h0000, 1, rd);
		check(rd[7:0], 8'h33);
		rtc_host_model_i.xfer(8'h8F, 16'hA53C, 2, rd);
		step(6);
		check({wr_cnt[3:0], o_wr_addr, o_wr_data}, 16'h303C);
		i_three_wire = 1'b0;
		press(50, 1'b0);
		press(250, 1'b1);
		i_powerfail_threshold_ok = 1'b0;
		i_osc_disable = 1'b1;
		step(10);
		check(o_rst_pin_oe_n, 1'b0);
		i_powerfail_threshold_ok = 1'b1;
		step(40);
		check(o_rst_pin_oe_n, 1'b0);
		step(30);
		check(o_rst_pin_oe_n, 1'b1);
		summarize();
	end
endmodule : tb_top

// [rtl/rtc_pins.sv]
// Serial link, reset pin, interrupt and square-wave pins of the real-time clock
// Summary of operation
// RQ1: Four-wire mode shifts address then data bits in from the serial input pin.
// RQ2: Serial output pin is driven push-pull only during a read transfer.
// RQ3: Three-wire mode uses one bidirectional line for input and read data.
// RQ4: All serial bits are timed on edges of the host serial clock.
// RQ5: Interrupt output asserts low only when its enable permits.
// RQ6: Interrupt and square wave keep running on main or backup supply.
// RQ7: Reset pin pulled low while main supply is below threshold.
// RQ8: After supply recovers, reset held for hold delay then released.
// RQ9: Reset pin doubles as debounced pushbutton input starting a reset cycle.
// RQ10: Oscillator disabled lengthens hold delay by oscillator start-up time.
// RQ11: Wave enable selects square wave on combined pin at one of four rates.
// RQ12: Separate open-drain square-wave pin independent of interrupt pin.
// RQ13: Host selects device with chip select per transfer and deselects after.
// RQ14: Time copied to shadow at transfer start; reads served from copy.
// RQ15: Serial reads and writes blocked while main supply below threshold.
// RQ16: Pushbutton low accepted only after fixed count of stable oscillator ticks.
module rtc_pins #(
	parameter int unsigned HOLD_CYCLES      = rtc_pins_pkg::RST_HOLD_CYC,
	parameter int unsigned OSC_START_CYCLES = rtc_pins_pkg::OSC_START_CYC
) (
	// Core clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	// Serial link
	input  wire logic        i_sclk,
	input  wire logic        i_three_wire,
	input  wire logic        i_cs_n,
	input  wire logic        i_ce,
	input  wire logic        i_din,
	output logic             o_dout,
	output logic             o_dout_oe_n,
	input  wire logic        i_sdio,
	output logic             o_sdio,
	output logic             o_sdio_oe_n,
	// Time source and write port toward the clock registers
	input  wire logic [63:0] i_time,
	output logic [3:0]       o_wr_addr,
	output logic [7:0]       o_wr_data,
	output logic             o_wr_valid,
	// Supply monitor, oscillator and control bits
	input  wire logic        i_powerfail_threshold_ok,
	input  wire logic        i_osc_clk,
	input  wire logic        i_osc_disable,
	input  wire logic        i_irq_enable,
	input  wire logic        i_wave_output_enable,
	input  wire logic [1:0]  i_rate_sel,
	input  wire logic        i_alarm_flag,
	// Reset pin, open drain
	input  wire logic        i_rst_pin,
	output logic             o_rst_pin,
	output logic             o_rst_pin_oe_n,
	// Open-drain event pins
	output logic             o_wave_or_irq_out,
	output logic             o_wave_or_irq_out_oe_n,
	output logic             o_irq_out,
	output logic             o_irq_out_oe_n,
	output logic             o_square_wave_out,
	output logic             o_square_wave_out_oe_n
);

	// ************************************************************
	// Link domain, clocked by the host serial clock
	// ************************************************************
	logic       sel_act;
	logic       frm_rst;
	logic       sdin;
	logic [2:0] bit_cnt_r;
	logic       addr_done_r;
	logic       wr_mode_r;
	logic [3:0] addr_r;
	logic [7:0] sh_r;
	logic [7:0] sh_nxt;
	logic [3:0] lk_wr_addr_r;
	logic [7:0] lk_wr_data_r;
	logic       lk_wr_tgl_r;
	logic       ok_s1_r;
	logic       ok_s2_r;
	logic [7:0] rd_byte;
	logic       rd_phase;
	logic       dout_r;
	logic       dout_oe_n_r;
	logic       sdio_oe_n_r;

	// Core-domain state read by the link
	logic [63:0] shadow_r;
	logic        access_ok_r;

	assign sel_act = i_three_wire ? i_ce : ~i_cs_n;  // RQ13
	// Deselect ends the frame even though the serial clock stops
	assign frm_rst = i_rst | ~sel_act;  // RQ13
	assign sdin    = i_three_wire ? i_sdio : i_din;  // RQ3
	assign sh_nxt  = {sh_r[6:0], sdin};  // RQ1
	assign rd_byte = addr_r[3] ? 8'h00 : shadow_r[{addr_r[2:0], 3'h0} +: rtc_pins_pkg::BYTE_W];  // RQ14
	assign rd_phase = addr_done_r & ~wr_mode_r & ok_s2_r;  // RQ2 RQ15

	// Access-allowed level into the link domain
	always_ff @(posedge i_sclk or posedge frm_rst) begin
		if (frm_rst) begin
			ok_s1_r <= 1'b0;
			ok_s2_r <= 1'b0;
		end else begin
			ok_s1_r <= access_ok_r;
			ok_s2_r <= ok_s1_r;
		end
	end

	// Shift in address then data on rising edges
	always_ff @(posedge i_sclk or posedge frm_rst) begin
		if (frm_rst) begin
			bit_cnt_r   <= 3'h0;
			addr_done_r <= 1'b0;
			wr_mode_r   <= 1'b0;
			addr_r      <= 4'h0;
			sh_r        <= 8'h00;
		end else begin
			sh_r      <= sh_nxt;  // RQ1 RQ4
			bit_cnt_r <= bit_cnt_r + 3'h1;
			if (bit_cnt_r == rtc_pins_pkg::LAST_BIT) begin
				if (!addr_done_r) begin
					addr_done_r <= 1'b1;
					wr_mode_r   <= sh_nxt[rtc_pins_pkg::WRITE_BIT];
					addr_r      <= sh_nxt[rtc_pins_pkg::ADDR_W-1:0];
				end else begin
					// Multibyte access wraps at the top address
					addr_r <= addr_r + 4'h1;
				end
			end
		end
	end

	// Completed write byte, held for a whole byte time while the core samples it
	always_ff @(posedge i_sclk or posedge i_rst) begin
		if (i_rst) begin
			lk_wr_addr_r <= 4'h0;
			lk_wr_data_r <= 8'h00;
			lk_wr_tgl_r  <= 1'b0;
		end else if (sel_act && addr_done_r && wr_mode_r && ok_s2_r
				&& bit_cnt_r == rtc_pins_pkg::LAST_BIT) begin
			lk_wr_addr_r <= addr_r;  // RQ15
			lk_wr_data_r <= sh_nxt;
			lk_wr_tgl_r  <= ~lk_wr_tgl_r;
		end
	end

	// Read data launched on falling edges, released when the frame ends
	always_ff @(negedge i_sclk or posedge frm_rst) begin
		if (frm_rst) begin
			dout_r      <= 1'b0;
			dout_oe_n_r <= 1'b1;
			sdio_oe_n_r <= 1'b1;
		end else begin
			dout_r      <= rd_phase & rd_byte[3'h7 - bit_cnt_r];  // RQ4 RQ14
			dout_oe_n_r <= ~(rd_phase & ~i_three_wire);  // RQ2
			sdio_oe_n_r <= ~(rd_phase & i_three_wire);  // RQ3
		end
	end

	assign o_dout      = dout_r;
	assign o_dout_oe_n = dout_oe_n_r;
	assign o_sdio      = dout_r;
	assign o_sdio_oe_n = sdio_oe_n_r;

	// ************************************************************
	// Core domain input synchronisers
	// ************************************************************
	logic       sel_s1_r, sel_s2_r, sel_s3_r;
	logic       tgl_s1_r, tgl_s2_r, tgl_s3_r;
	logic       pwr_s1_r, pwr_s2_r;
	logic       osc_s1_r, osc_s2_r, osc_s3_r;
	logic       pin_s1_r, pin_s2_r;
	logic       osc_tick;

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			sel_s1_r <= 1'b0;
			sel_s2_r <= 1'b0;
			sel_s3_r <= 1'b0;
			tgl_s1_r <= 1'b0;
			tgl_s2_r <= 1'b0;
			tgl_s3_r <= 1'b0;
			pwr_s1_r <= 1'b0;
			pwr_s2_r <= 1'b0;
			osc_s1_r <= 1'b0;
			osc_s2_r <= 1'b0;
			osc_s3_r <= 1'b0;
			pin_s1_r <= 1'b1;
			pin_s2_r <= 1'b1;
		end else begin
			sel_s1_r <= sel_act;
			sel_s2_r <= sel_s1_r;
			sel_s3_r <= sel_s2_r;
			tgl_s1_r <= lk_wr_tgl_r;
			tgl_s2_r <= tgl_s1_r;
			tgl_s3_r <= tgl_s2_r;
			pwr_s1_r <= i_powerfail_threshold_ok;
			pwr_s2_r <= pwr_s1_r;
			osc_s1_r <= i_osc_clk;
			osc_s2_r <= osc_s1_r;
			osc_s3_r <= osc_s2_r;
			pin_s1_r <= i_rst_pin;
			pin_s2_r <= pin_s1_r;
		end
	end

	assign osc_tick = osc_s2_r & ~osc_s3_r;

	// ************************************************************
	// Shadow copy and write hand-off
	// ************************************************************
	logic [3:0] wr_addr_r;
	logic [7:0] wr_data_r;
	logic       wr_valid_r;

	// Shadow is still during the frame, so the link may read it directly
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			shadow_r <= 64'h0;
		end else if (sel_s2_r && !sel_s3_r && access_ok_r) begin
			shadow_r <= i_time;  // RQ14
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			wr_addr_r  <= 4'h0;
			wr_data_r  <= 8'h00;
			wr_valid_r <= 1'b0;
		end else begin
			wr_valid_r <= (tgl_s2_r ^ tgl_s3_r) & access_ok_r;  // RQ15
			if (tgl_s2_r ^ tgl_s3_r) begin
				wr_addr_r <= lk_wr_addr_r;
				wr_data_r <= lk_wr_data_r;
			end
		end
	end

	assign o_wr_addr  = wr_addr_r;
	assign o_wr_data  = wr_data_r;
	assign o_wr_valid = wr_valid_r;

	// ************************************************************
	// Reset pin sequencer
	// ************************************************************
	rtc_pins_pkg::rst_state_t           rst_state_r;
	rtc_pins_pkg::rst_state_t           rst_state_nxt;
	logic [rtc_pins_pkg::HOLD_CNT_W-1:0] hold_cnt_r;
	logic [rtc_pins_pkg::HOLD_CNT_W-1:0] hold_load;
	logic [4:0]                          deb_cnt_r;
	logic                                press;
	logic                                rst_oe_n_r;

	assign hold_load = rtc_pins_pkg::HOLD_CNT_W'(HOLD_CYCLES)
		+ (i_osc_disable ? rtc_pins_pkg::HOLD_CNT_W'(OSC_START_CYCLES) : '0);  // RQ10
	assign press = deb_cnt_r == rtc_pins_pkg::DEBOUNCE_TICKS;

	// Low level must stay for a fixed count of oscillator ticks
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			deb_cnt_r <= 5'h00;
		end else if (pin_s2_r || rst_state_r != rtc_pins_pkg::RST_IDLE) begin
			deb_cnt_r <= 5'h00;  // RQ16
		end else if (osc_tick && !press) begin
			deb_cnt_r <= deb_cnt_r + 5'h01;  // RQ16
		end
	end

	always_comb begin
		rst_state_nxt = rst_state_r;
		case (rst_state_r)
			rtc_pins_pkg::RST_FAULT: begin
				if (pwr_s2_r) begin
					rst_state_nxt = rtc_pins_pkg::RST_HOLD;  // RQ8
				end
			end
			rtc_pins_pkg::RST_HOLD: begin
				if (!pwr_s2_r) begin
					rst_state_nxt = rtc_pins_pkg::RST_FAULT;  // RQ7
				end else if (hold_cnt_r == '0) begin
					rst_state_nxt = rtc_pins_pkg::RST_IDLE;  // RQ8
				end
			end
			rtc_pins_pkg::RST_IDLE: begin
				if (!pwr_s2_r) begin
					rst_state_nxt = rtc_pins_pkg::RST_FAULT;  // RQ7
				end else if (press) begin
					rst_state_nxt = rtc_pins_pkg::RST_HOLD;  // RQ9
				end
			end
			default: begin
				rst_state_nxt = rtc_pins_pkg::RST_FAULT;
			end
		endcase
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rst_state_r <= rtc_pins_pkg::RST_FAULT;
			hold_cnt_r  <= '0;
			rst_oe_n_r  <= 1'b0;
			access_ok_r <= 1'b0;
		end else begin
			rst_state_r <= rst_state_nxt;
			if (rst_state_r != rtc_pins_pkg::RST_HOLD) begin
				hold_cnt_r <= hold_load;  // RQ8 RQ10
			end else if (hold_cnt_r != '0) begin
				hold_cnt_r <= hold_cnt_r - 1'b1;
			end
			rst_oe_n_r  <= rst_state_nxt == rtc_pins_pkg::RST_IDLE;  // RQ7 RQ8
			access_ok_r <= rst_state_nxt == rtc_pins_pkg::RST_IDLE;  // RQ15
		end
	end

	// ************************************************************
	// Square wave and interrupt pins
	// ************************************************************
	logic [rtc_pins_pkg::DIV_W-1:0] div_r;
	logic                           wave;
	logic                           irq_act;
	logic                           od_low_r;
	logic                           combo_oe_n_r;
	logic                           irq_oe_n_r;
	logic                           sqw_oe_n_r;

	// Divider runs from the oscillator alone, independent of main supply
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			div_r <= '0;
		end else if (osc_tick) begin
			div_r <= div_r + 1'b1;  // RQ6
		end
	end

	always_comb begin
		case (i_rate_sel)
			rtc_pins_pkg::RATE_1HZ:    wave = div_r[rtc_pins_pkg::TAP_1HZ];  // RQ11
			rtc_pins_pkg::RATE_4K096:  wave = div_r[rtc_pins_pkg::TAP_4K096];
			rtc_pins_pkg::RATE_8K192:  wave = div_r[rtc_pins_pkg::TAP_8K192];
			rtc_pins_pkg::RATE_32K768: wave = osc_s3_r;
			default:                   wave = 1'b1;
		endcase
	end

	assign irq_act = i_alarm_flag & i_irq_enable;  // RQ5

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			od_low_r     <= 1'b0;
			combo_oe_n_r <= 1'b1;
			irq_oe_n_r   <= 1'b1;
			sqw_oe_n_r   <= 1'b1;
		end else begin
			od_low_r     <= 1'b0;
			combo_oe_n_r <= i_wave_output_enable ? wave : ~irq_act;  // RQ5 RQ6 RQ11
			irq_oe_n_r   <= ~irq_act;  // RQ5
			sqw_oe_n_r   <= i_wave_output_enable ? wave : 1'b1;  // RQ12
		end
	end

	assign o_rst_pin              = od_low_r;
	assign o_rst_pin_oe_n         = rst_oe_n_r;
	assign o_wave_or_irq_out      = od_low_r;
	assign o_wave_or_irq_out_oe_n = combo_oe_n_r;
	assign o_irq_out              = od_low_r;
	assign o_irq_out_oe_n         = irq_oe_n_r;
	assign o_square_wave_out      = od_low_r;
	assign o_square_wave_out_oe_n = sqw_oe_n_r;

endmodule : rtc_pins

// [shared/rtc_pins_pkg.sv]
// Constants shared by the real-time clock pin logic
package rtc_pins_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int unsigned CORE_CLK_MHZ     = 250;
	localparam int unsigned RST_HOLD_MS      = 250;
	localparam int unsigned OSC_START_MS     = 1000;
	localparam int unsigned RST_HOLD_CYC     = RST_HOLD_MS * CORE_CLK_MHZ * 1000;
	localparam int unsigned OSC_START_CYC    = OSC_START_MS * CORE_CLK_MHZ * 1000;
	localparam int unsigned HOLD_CNT_W       = 32;
	localparam logic [4:0]  DEBOUNCE_TICKS   = 5'h10;

	// ************************************************************
	// Serial frame layout
	// ************************************************************
	localparam int unsigned BYTE_W           = 8;
	localparam int unsigned ADDR_W           = 4;
	localparam int unsigned WRITE_BIT        = 7;
	localparam int unsigned SHADOW_BYTES     = 8;
	localparam logic [2:0]  LAST_BIT         = 3'h7;

	// ************************************************************
	// Square-wave rate select and divider taps
	// ************************************************************
	localparam logic [1:0]  RATE_1HZ         = 2'h0;
	localparam logic [1:0]  RATE_4K096       = 2'h1;
	localparam logic [1:0]  RATE_8K192       = 2'h2;
	localparam logic [1:0]  RATE_32K768      = 2'h3;
	localparam int unsigned DIV_W            = 15;
	localparam int unsigned TAP_1HZ          = 14;
	localparam int unsigned TAP_4K096        = 2;
	localparam int unsigned TAP_8K192        = 1;

	// ************************************************************
	// Reset pin sequencer
	// ************************************************************
	typedef enum logic [1:0] {
		RST_FAULT,
		RST_HOLD,
		RST_IDLE
	} rst_state_t;

endpackage : rtc_pins_pkg
